/* File: design/sccd_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module sccd_decoder
	import sccd_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = SCCD_TMO_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Received message stream
	input wire logic msg_valid,
	input wire logic [10:0] msg_id,
	input wire logic [3:0] msg_len,
	input wire logic [63:0] msg_data,
	// Antenna data and timing
	input wire logic [63:0] correlator_antenna_input,
	input wire logic tick_16ms,
	output logic [6:0] sum_out,
	output logic irq,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// All state of the block except the pattern stage in one record, registered as a whole
	typedef struct packed {
		sccd_fsm_t st;
		logic [16:0] tmo;
		logic [63:0] mask;
		logic [2:0] mode;
		logic warn;
		logic err;
		logic [5:0] node;
		logic [SCCD_EV_N-1:0] irq_sts;
		logic [SCCD_EV_N-1:0] irq_en;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sccd_core_t;

	sccd_core_t s_reg;
	sccd_core_t s_next;

	// Helpers between the state record and the next-state logic
	logic [63:0] masked;
	logic [6:0] sum_cnt;
	logic full_len;
	logic [47:0] target;
	logic addressed;
	logic [SCCD_EV_N-1:0] ev;
	logic [SCCD_EV_N-1:0] clr;
	logic wr_fire;
	logic [31:0] rd_val;
	logic rd_ok;

	// Per-antenna gating of the input data by the active mask
	genvar gi;
	generate
		for (gi = 0; gi < 64; gi++) begin : g_gate
			assign masked[gi] = correlator_antenna_input[gi] & s_reg.mask[gi];
		end
	endgenerate

	// Count of included antenna bits forms the normal sum
	// A plain chain of 64 one-bit adds; seven bits hold the full count
	always_comb begin
		sum_cnt = 7'h00;
		for (int i = 0; i < 64; i++) begin
			sum_cnt = sum_cnt + {6'h00, masked[i]};
		end
	end

	// Setup target mask covers 48 nodes; bytes 2..7 of the setup payload
	assign target = msg_data[63:16];
	// Node numbers above 47 have no target bit and are never addressed
	assign addressed = (s_reg.node < 6'h30) && target[s_reg.node];
	assign full_len = (msg_len == SCCD_MSG_LEN);

	// Register read mux
	// Write-only and unmapped offsets read as zero; only the reply code differs
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			SCCD_REG_CTRL: rd_val = {26'h0, s_reg.node};
			SCCD_REG_STATUS: rd_val = {25'h0, s_reg.st, s_reg.err, s_reg.warn, s_reg.mode};
			SCCD_REG_MASK_LO: rd_val = s_reg.mask[31:0];
			SCCD_REG_MASK_HI: rd_val = s_reg.mask[63:32];
			SCCD_REG_IRQ_STATUS: rd_val = {27'h0, s_reg.irq_sts};
			SCCD_REG_IRQ_CLEAR: rd_val = 32'h0000_0000;
			SCCD_REG_IRQ_ENABLE: rd_val = {27'h0, s_reg.irq_en};
			default: rd_ok = 1'b0;
		endcase
	end

	// Write completes once both address and data are held
	// A pending response blocks the next write until it is accepted
	assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;

	// Main next-state process: decoder, registers, bus slave
	always_comb begin
		s_next = s_reg;
		ev = '0;
		clr = '0;

		// Sequence timeout runs while a command is part-received
		// A lost message would otherwise leave a half command armed forever
		if (s_reg.st != SCCD_IDLE) begin
			s_next.tmo = s_reg.tmo + 17'h00001;
		end
		if (s_reg.st != SCCD_IDLE && s_reg.tmo >= 17'(TIMEOUT_CYCLES - 1)) begin
			s_next.st = SCCD_IDLE;
			s_next.tmo = 17'h00000;
			ev[SCCD_EV_DISCARD] = 1'b1;
		end

		// Message decoder
		if (msg_valid) begin
			if (!full_len) begin
				// Short payloads break the sequence
				if (s_reg.st != SCCD_IDLE) begin
					ev[SCCD_EV_DISCARD] = 1'b1;
				end
				s_next.st = SCCD_IDLE;
				s_next.tmo = 17'h00000;
			end else if (msg_id == SCCD_ID_SETUP) begin
				// A new setup always restarts; a stale sequence is dropped
				if (s_reg.st != SCCD_IDLE) begin
					ev[SCCD_EV_DISCARD] = 1'b1;
				end
				s_next.tmo = 17'h00000;
				if (msg_data[7:0] == SCCD_PAYLOAD_ID && addressed) begin
					s_next.st = SCCD_WAIT_HDR;
				end else begin
					s_next.st = SCCD_IDLE;
				end
			end else if (msg_id == SCCD_ID_HEADER) begin
				case (s_reg.st)
					SCCD_WAIT_HDR: begin
						s_next.tmo = 17'h00000;
						s_next.st = SCCD_IDLE;
						if (msg_data[7:0] == SCCD_FC_SUM_MASK
							&& msg_data[15:8] == SCCD_STRUCT_MASK
							&& msg_data[23:16] == SCCD_MASK_SIZE_LO
							&& msg_data[31:24] == SCCD_MASK_SIZE_HI) begin
							s_next.st = SCCD_WAIT_DATA;
						end else if (msg_data[7:0] == SCCD_FC_SUM_MODE) begin
							// Mode lives in header byte 1, no data message
							// Spare header bytes beyond byte 1 are not checked
							if (msg_data[10:8] <= SCCD_MODE_COUNT
								&& msg_data[15:11] == 5'h00) begin
								s_next.mode = msg_data[10:8];
								s_next.err = 1'b0;
								ev[SCCD_EV_MODE] = 1'b1;
							end else begin
								// Out-of-range mode keeps the running source
								s_next.err = 1'b1;
								ev[SCCD_EV_ERR] = 1'b1;
							end
						end
					end
					SCCD_WAIT_DATA: begin
						// Header where data was due ends the sequence
						s_next.st = SCCD_IDLE;
						s_next.tmo = 17'h00000;
						ev[SCCD_EV_DISCARD] = 1'b1;
					end
					SCCD_IDLE: s_next.st = SCCD_IDLE;
					default: s_next.st = SCCD_IDLE;
				endcase
			end else if (msg_id == SCCD_ID_DATA) begin
				if (s_reg.st == SCCD_WAIT_DATA) begin
					// Byte 0 in bits 7:0 covers inputs 7..0
					// Top input returns the phased sum, so it never joins the mask
					s_next.mask = {1'b0, msg_data[62:0]};
					s_next.warn = msg_data[63];
					ev[SCCD_EV_MASK] = 1'b1;
					ev[SCCD_EV_WARN] = msg_data[63];
				end else if (s_reg.st == SCCD_WAIT_HDR) begin
					ev[SCCD_EV_DISCARD] = 1'b1;
				end
				s_next.st = SCCD_IDLE;
				s_next.tmo = 17'h00000;
			end
		end

		// Write channel capture; address and data in either order
		// Each half stays held until the write fires; no new half is taken while a response waits
		if (s_axi_awvalid && !s_reg.aw_got && !s_reg.bvalid) begin
			s_next.aw_got = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_reg.w_got && !s_reg.bvalid) begin
			s_next.w_got = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		// All fields sit in byte lane 0; other lanes are ignored
		if (wr_fire) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = SCCD_RESP_OKAY;
			case (s_reg.aw_addr)
				SCCD_REG_CTRL: begin
					if (s_reg.w_strb[0]) begin
						s_next.node = s_reg.w_data[5:0];
					end
				end
				SCCD_REG_IRQ_CLEAR: begin
					if (s_reg.w_strb[0]) begin
						clr = s_reg.w_data[SCCD_EV_N-1:0];
					end
				end
				SCCD_REG_IRQ_ENABLE: begin
					if (s_reg.w_strb[0]) begin
						s_next.irq_en = s_reg.w_data[SCCD_EV_N-1:0];
					end
				end
				SCCD_REG_STATUS, SCCD_REG_MASK_LO, SCCD_REG_MASK_HI,
				SCCD_REG_IRQ_STATUS: s_next.bresp = SCCD_RESP_OKAY;
				default: s_next.bresp = SCCD_RESP_SLVERR;
			endcase
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end

		// Read channel, one outstanding read
		// Read data comes from the live address in the acceptance cycle
		if (s_axi_arvalid && !s_reg.rvalid) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = rd_val;
			s_next.rresp = rd_ok ? SCCD_RESP_OKAY : SCCD_RESP_SLVERR;
		end else if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end

		// Sticky events; a set in the clear cycle wins
		// Clearing never hides an event that lands in the same cycle
		s_next.irq_sts = (s_reg.irq_sts & ~clr) | ev;
	end

	// State register; clock enable freezes everything
	// Reset does not wait for the clock enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '{
				st: SCCD_IDLE,
				tmo: 17'h00000,
				mask: SCCD_MASK_RST,
				mode: SCCD_MODE_RST,
				warn: 1'b0,
				err: 1'b0,
				node: SCCD_NODE_RST,
				irq_sts: '0,
				irq_en: '0,
				aw_got: 1'b0,
				aw_addr: 8'h00,
				w_got: 1'b0,
				w_data: 32'h0000_0000,
				w_strb: 4'h0,
				bvalid: 1'b0,
				bresp: SCCD_RESP_OKAY,
				rvalid: 1'b0,
				rdata: 32'h0000_0000,
				rresp: SCCD_RESP_OKAY
			};
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// Source selection and test patterns
	// The pattern stage adds one register after the adder chain
	sccd_pattern_gen u_pat (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.mode(s_reg.mode),
		.tick_16ms(tick_16ms),
		.sum_in(sum_cnt),
		.sum_out(sum_out)
	);

	// Handshake outputs; ready is withheld while the clock enable is low
	// Data and response outputs come straight from the state record
	assign s_axi_awready = ce && !s_reg.aw_got && !s_reg.bvalid;
	assign s_axi_wready = ce && !s_reg.w_got && !s_reg.bvalid;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = ce && !s_reg.rvalid;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	// Level interrupt from registered status and enable
	assign irq = |(s_reg.irq_sts & s_reg.irq_en);

endmodule // sccd_decoder
`default_nettype wire

/* File: design/sccd_pattern_gen.sv */
`timescale 1ns/100ps
`default_nettype none
module sccd_pattern_gen
	import sccd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [2:0] mode,
	input wire logic tick_16ms,
	input wire logic [6:0] sum_in,
	output logic [6:0] sum_out
);

	typedef struct packed {
		logic [15:0] lfsr;
		logic [6:0] cnt;
		logic [6:0] out;
	} sccd_pat_t;

	sccd_pat_t s_reg;
	sccd_pat_t s_next;
	logic fb;

	// Next pattern and selected source
	always_comb begin
		s_next = s_reg;
		fb = s_reg.lfsr[15] ^ s_reg.lfsr[13] ^ s_reg.lfsr[12] ^ s_reg.lfsr[10];
		s_next.cnt = s_reg.cnt + 7'h01;
		if (mode == SCCD_MODE_PRN_SYNC && tick_16ms) begin
			s_next.lfsr = SCCD_PRN_SEED;
		end else begin
			s_next.lfsr = {s_reg.lfsr[14:0], fb};
		end
		case (mode)
			SCCD_MODE_NORMAL: s_next.out = sum_in;
			SCCD_MODE_ZERO: s_next.out = 7'h00;
			SCCD_MODE_PRN_SYNC: s_next.out = s_reg.lfsr[6:0];
			SCCD_MODE_PRN_FREE: s_next.out = s_reg.lfsr[6:0];
			SCCD_MODE_COUNT: s_next.out = s_reg.cnt;
			default: s_next.out = sum_in;
		endcase
	end

	// State register, frozen by clock enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '{lfsr: SCCD_PRN_SEED, cnt: 7'h00, out: 7'h00};
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign sum_out = s_reg.out;

endmodule // sccd_pattern_gen
`default_nettype wire

/* File: design/sccd_pkg.sv */
package sccd_pkg;

	// Message identifiers and command codes
	localparam logic [10:0] SCCD_ID_SETUP = 11'h005;
	localparam logic [10:0] SCCD_ID_HEADER = 11'h008;
	localparam logic [10:0] SCCD_ID_DATA = 11'h009;
	localparam logic [7:0] SCCD_PAYLOAD_ID = 8'h08;
	localparam logic [3:0] SCCD_MSG_LEN = 4'h8;
	localparam logic [7:0] SCCD_FC_SUM_MASK = 8'h02;
	localparam logic [7:0] SCCD_STRUCT_MASK = 8'h0B;
	localparam logic [7:0] SCCD_FC_SUM_MODE = 8'h0B;
	localparam logic [7:0] SCCD_MASK_SIZE_LO = 8'h08;
	localparam logic [7:0] SCCD_MASK_SIZE_HI = 8'h00;

	// Sum source modes
	localparam logic [2:0] SCCD_MODE_NORMAL = 3'h0;
	localparam logic [2:0] SCCD_MODE_ZERO = 3'h1;
	localparam logic [2:0] SCCD_MODE_PRN_SYNC = 3'h2;
	localparam logic [2:0] SCCD_MODE_PRN_FREE = 3'h3;
	localparam logic [2:0] SCCD_MODE_COUNT = 3'h4;

	// Register byte offsets
	localparam logic [7:0] SCCD_REG_CTRL = 8'h00;
	localparam logic [7:0] SCCD_REG_STATUS = 8'h04;
	localparam logic [7:0] SCCD_REG_MASK_LO = 8'h08;
	localparam logic [7:0] SCCD_REG_MASK_HI = 8'h0C;
	localparam logic [7:0] SCCD_REG_IRQ_STATUS = 8'h10;
	localparam logic [7:0] SCCD_REG_IRQ_CLEAR = 8'h14;
	localparam logic [7:0] SCCD_REG_IRQ_ENABLE = 8'h18;

	// Event bit positions
	localparam int SCCD_EV_MASK = 0;
	localparam int SCCD_EV_MODE = 1;
	localparam int SCCD_EV_WARN = 2;
	localparam int SCCD_EV_ERR = 3;
	localparam int SCCD_EV_DISCARD = 4;
	localparam int SCCD_EV_N = 5;

	// Reset values
	localparam logic [63:0] SCCD_MASK_RST = 64'h0000_0000_0000_0000;
	localparam logic [2:0] SCCD_MODE_RST = 3'h0;
	localparam logic [5:0] SCCD_NODE_RST = 6'h00;
	localparam logic [15:0] SCCD_PRN_SEED = 16'hACE1;

	// Sequence timeout
	localparam int SCCD_CLK_HZ = 10_000_000;
	localparam int SCCD_TMO_MS = 10;
	localparam int SCCD_TMO_CYCLES = SCCD_TMO_MS * (SCCD_CLK_HZ / 1000);

	localparam logic [1:0] SCCD_RESP_OKAY = 2'h0;
	localparam logic [1:0] SCCD_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SCCD_IDLE,
		SCCD_WAIT_HDR,
		SCCD_WAIT_DATA
	} sccd_fsm_t;

endpackage

/* File: tb/sccd_decoder_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module sccd_decoder_sva
	import sccd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic msg_valid,
	input wire logic [10:0] msg_id,
	input wire logic [3:0] msg_len,
	input wire logic [63:0] msg_data,
	input wire logic [63:0] correlator_antenna_input,
	input wire logic [6:0] sum_out,
	input wire logic irq,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// Frozen cycles are not judged
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);
	// Command steps as the host sends them, node 0 addressed
	sequence s_setup;
		msg_valid && msg_id == SCCD_ID_SETUP && msg_len == SCCD_MSG_LEN
			&& msg_data[7:0] == SCCD_PAYLOAD_ID && msg_data[16];
	endsequence
	sequence s_hdr(logic [31:0] w);
		msg_valid && msg_id == SCCD_ID_HEADER && msg_len == SCCD_MSG_LEN && msg_data[31:0] == w;
	endsequence
	sequence s_data;
		msg_valid && msg_id == SCCD_ID_DATA && msg_len == SCCD_MSG_LEN;
	endsequence
	// Holds only while the bench keeps mode 0 during mask commands
	property p_mask;
		logic [6:0] n;
		s_setup ##[1:3] s_hdr(32'h0008_0B02) ##[1:3]
			(s_data, n = 7'($countones(msg_data[62:0] & correlator_antenna_input[62:0])))
			|-> ##[2:3] sum_out == n;
	endproperty
	AST_MASK_SUM: assert property (p_mask)
		else $error("sum does not follow new mask");
	AST_ZERO_MODE: assert property (s_setup ##[1:3] s_hdr(32'h0000_010B) |-> ##3 (sum_out == 7'h00) [*4])
		else $error("mode 1 output not zero");
	AST_RESET: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && sum_out == 7'h00)
		else $error("outputs not cleared by reset");
	AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response latency wrong");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response latency wrong");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while response pending");
endmodule // sccd_decoder_sva
bind sccd_decoder sccd_decoder_sva u_sccd_decoder_sva (.aclk(aclk), .aresetn(aresetn), .ce(ce),
	.msg_valid(msg_valid), .msg_id(msg_id), .msg_len(msg_len), .msg_data(msg_data),
	.correlator_antenna_input(correlator_antenna_input), .sum_out(sum_out), .irq(irq),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

/* File: tb/sccd_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sccd_host_model
	import sccd_pkg::*;
(
	input wire logic aclk,
	output logic msg_valid,
	output logic [10:0] msg_id,
	output logic [3:0] msg_len,
	output logic [63:0] msg_data
);
	initial begin
		msg_valid = 1'b0;
		msg_id = 11'h000;
		msg_len = 4'h0;
		msg_data = 64'h0;
	end
	// One message per two clocks; stale payload inverted so it never looks valid
	task automatic send(input logic [10:0] id, input logic [3:0] len, input logic [63:0] d);
		@(posedge aclk);
		msg_valid <= 1'b1;
		msg_id <= id;
		msg_len <= len;
		msg_data <= d;
		@(posedge aclk);
		msg_valid <= 1'b0;
		msg_data <= ~d;
	endtask
	// Setup, header, then data when asked; bit 16 of tgt is node 0
	task automatic cmd(input logic [63:0] tgt, input logic [63:0] hdr, input logic dat,
		input logic [63:0] d);
		send(SCCD_ID_SETUP, SCCD_MSG_LEN, tgt | 64'(SCCD_PAYLOAD_ID));
		send(SCCD_ID_HEADER, SCCD_MSG_LEN, hdr);
		if (dat) begin
			send(SCCD_ID_DATA, SCCD_MSG_LEN, d);
		end
	endtask
endmodule // sccd_host_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb import sccd_pkg::*;;
	logic aclk, aresetn, ce, tick_16ms, irq, msg_valid;
	logic [10:0] msg_id;
	logic [3:0] msg_len, s_axi_wstrb;
	logic [63:0] msg_data, ant;
	logic [6:0] sum_out;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, br;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [6:0] s0;
	int num_errors, n_compared, cyc;
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	sccd_decoder #(.TIMEOUT_CYCLES(50)) u_sccd_decoder (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.msg_valid(msg_valid), .msg_id(msg_id), .msg_len(msg_len), .msg_data(msg_data),
		.correlator_antenna_input(ant), .tick_16ms(tick_16ms), .sum_out(sum_out), .irq(irq),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	sccd_host_model u_sccd_host_model (.aclk(aclk), .msg_valid(msg_valid), .msg_id(msg_id),
		.msg_len(msg_len), .msg_data(msg_data));
	task automatic test_done();
		if (num_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Readies depend on registered state and ce only, so the negedge value holds at the next edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		fork
			begin
				do @(negedge aclk); while (s_axi_awready !== 1'b1);
				@(posedge aclk);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(negedge aclk); while (s_axi_wready !== 1'b1);
				@(posedge aclk);
				s_axi_wvalid <= 1'b0;
			end
		join
		// Late bready leaves bvalid waiting one cycle
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		@(posedge aclk);
		s_axi_bready <= 1'b1;
		@(negedge aclk);
		br = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		// Late rready leaves rvalid waiting one cycle
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(nm, e, v);
	endtask
	task automatic sum_is(input logic [6:0] e);
		repeat (4) @(negedge aclk);
		chk("sum_out", 32'(e), 32'(sum_out));
	endtask
	// Hang guard and a periodic timing tick
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		tick_16ms <= (cyc % 200 == 0);
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		ce = 1'b1;
		s_axi_wstrb = 4'hF;
		ant = 64'hFFFF_FFFF_FFFF_FFFF;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rc("status", SCCD_REG_STATUS, 32'h0);
		rc("mask_hi", SCCD_REG_MASK_HI, 32'h0);
		wr(SCCD_REG_MASK_LO, 32'hFFFF_FFFF);
		chk("bresp read-only", 32'(SCCD_RESP_OKAY), 32'(br));
		rc("mask_lo", SCCD_REG_MASK_LO, 32'h0);
		wr(SCCD_REG_IRQ_ENABLE, 32'h1F);
		rc("irq_enable", SCCD_REG_IRQ_ENABLE, 32'h1F);
		rd(8'h1C);
		chk("unmapped resp", 32'(SCCD_RESP_SLVERR), 32'(r));
		chk("unmapped data", 32'h0, v);
		wr(8'h1C, 32'h0);
		chk("bresp unmapped", 32'(SCCD_RESP_SLVERR), 32'(br));
		u_sccd_host_model.cmd(64'h1_0000, 64'h0008_0B02, 1'b1, 64'h8100_0000_0001_00F0);
		sum_is(7'h06);
		chk("irq", 32'h1, 32'(irq));
		rc("mask_lo", SCCD_REG_MASK_LO, 32'h0001_00F0);
		rc("mask_hi", SCCD_REG_MASK_HI, 32'h0100_0000);
		rc("status", SCCD_REG_STATUS, 32'h8);
		rc("irq_status", SCCD_REG_IRQ_STATUS, 32'h5);
		wr(SCCD_REG_IRQ_CLEAR, 32'h1F);
		chk("irq", 32'h0, 32'(irq));
		u_sccd_host_model.cmd(64'h1_0000, 64'h0008_0B02, 1'b1, 64'h4000_0000_0000_0003);
		rc("mask_hi", SCCD_REG_MASK_HI, 32'h4000_0000);
		rc("status", SCCD_REG_STATUS, 32'h0);
		u_sccd_host_model.cmd(64'h1_0000, 64'h0008_0A02, 1'b1, 64'hFF);
		u_sccd_host_model.cmd(64'h1_0000, 64'h0009_0B02, 1'b1, 64'hFF);
		u_sccd_host_model.cmd(64'h2_0000, 64'h0008_0B02, 1'b1, 64'hFF);
		u_sccd_host_model.send(SCCD_ID_SETUP, SCCD_MSG_LEN, 64'h1_0008);
		u_sccd_host_model.send(SCCD_ID_HEADER, 4'h7, 64'h0008_0B02);
		u_sccd_host_model.send(SCCD_ID_DATA, SCCD_MSG_LEN, 64'hFF);
		rc("mask_lo", SCCD_REG_MASK_LO, 32'h3);
		wr(SCCD_REG_IRQ_CLEAR, 32'h1F);
		u_sccd_host_model.cmd(64'h1_0000, 64'h0008_0B02, 1'b0, 64'h0);
		repeat (60) @(posedge aclk);
		u_sccd_host_model.send(SCCD_ID_DATA, SCCD_MSG_LEN, 64'hFF);
		rc("mask_lo", SCCD_REG_MASK_LO, 32'h3);
		rc("irq_status", SCCD_REG_IRQ_STATUS, 32'h10);
		for (int m = 0; m < 5; m++) begin
			u_sccd_host_model.cmd(64'h1_0000, (64'(m) << 8) | 64'h0B, 1'b0, 64'h0);
			rc("status mode", SCCD_REG_STATUS, 32'(m));
			if (m < 2) begin
				sum_is(m == 0 ? 7'h03 : 7'h00);
			end
			if (m == 2) begin
				do @(negedge aclk); while (tick_16ms !== 1'b1);
				repeat (2) @(negedge aclk);
				chk("prn reseed", 32'(SCCD_PRN_SEED[6:0]), 32'(sum_out));
			end
		end
		@(negedge aclk);
		s0 = sum_out;
		@(negedge aclk);
		chk("counter step", 32'(s0 + 7'h01), 32'(sum_out));
		// Clock enable low must freeze the running counter
		@(posedge aclk);
		ce <= 1'b0;
		@(negedge aclk);
		s0 = sum_out;
		repeat (3) @(negedge aclk);
		chk("frozen sum_out", 32'(s0), 32'(sum_out));
		@(posedge aclk);
		ce <= 1'b1;
		u_sccd_host_model.cmd(64'h1_0000, 64'h050B, 1'b0, 64'h0);
		rc("status bad mode", SCCD_REG_STATUS, 32'h14);
		u_sccd_host_model.cmd(64'h1_0000, 64'h030B, 1'b0, 64'h0);
		rc("status mode", SCCD_REG_STATUS, 32'h3);
		test_done();
	end
endmodule // tb
`default_nettype wire
